// ===== flow_trig_consts.svh
// Offsets, field positions, reset values and timing figures of the flow trigger
// Assumes inclusion by bare name from the package and the design file
`ifndef FLOW_TRIG_CONSTS_SVH
`define FLOW_TRIG_CONSTS_SVH

// ***************************************
// Register byte addresses
// ***************************************
`define ADDR_CTRL        8'h00
`define ADDR_STATUS      8'h04
`define ADDR_FLOW_CFG    8'hAC

// ***************************************
// Field positions and reset values
// ***************************************
`define CFG_HI_LSB       16
`define CFG_LO_LSB       8
`define CFG_DUR_LSB      4
`define CFG_RST          24'h00_0000
`define CTRL_RST         3'h0
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2
`define THR_UNIT_BITS    6

// ***************************************
// Timing
// ***************************************
`define CLK_PERIOD_NS    50
`define JAM_T0_NS        5000
`define JAM_T1_NS        10000
`define JAM_T2_NS        15000
`define JAM_T3_NS        25000
`define JAM_STEP_NS      50000
`define JAM_EXTRA_10M_NS 2200

`endif

// ===== flow_trig_pkg.sv
// Types shared by the flow trigger design and its bench
// Assumes the constants header is on the include path
package flow_trig_pkg;
   `include "flow_trig_consts.svh"

   typedef struct packed {
      logic [7:0] flow_high_threshold;
      logic [7:0] flow_low_threshold;
      logic [3:0] jam_duration_select;
      logic       multicast_flow_trigger;
      logic       broadcast_flow_trigger;
      logic       address_match_flow_trigger;
      logic       any_frame_flow_trigger;
   } flow_cfg_t;

   typedef struct packed {
      logic speed_100;
      logic full_duplex;
      logic tx_enable;
   } ctrl_t;

   typedef struct packed {
      logic valid;
      logic mcast;
      logic bcast;
      logic match;
   } da_info_t;

   typedef enum logic {J_IDLE, J_JAM} jam_state_t;
endpackage

// ===== flow_trigger.sv
// Receive flow control trigger with an AXI4-Lite register slave
// Assumes buffer level and frame decode come from logic on I_CLK
// Overview of operation
// - With any-frame set and the level at the high mark, any frame draws a jam in half duplex; full duplex pauses on the crossing.
// - Any-frame is the only enable of automatic pause in full duplex.
// - Half duplex with any-frame jams on a valid preamble with no address decode.
// - Full duplex with any-frame requests a pause on reaching the high mark, once no frame is in flight.
// - A pause request is held until the MAC takes it and waits for a frame in flight.
// - Any-frame overrides the multicast, broadcast and address triggers.
// - The duration code picks 5..25 us then 50..600 us steps, 2.2 us more at 10 Mb/s.
// - The high mark is in 64-byte units and in full duplex gives one pause per crossing.
// - Below the low mark a zero-time pause goes out only after a high-mark pause.
// - Back pressure lasts the chosen time and the code is unused in full duplex.
// - With the transmitter disabled no pause is sent and no jam is raised.
`timescale 1ns/100ps
`include "flow_trig_consts.svh"

module flow_trigger
   import flow_trig_pkg::*;
#(
   parameter int JAM_STEP_CYCLES = `JAM_STEP_NS / `CLK_PERIOD_NS
) (
   input  wire logic        I_CLK,
   input  wire logic        I_RST_B,
   input  wire logic [7:0]  I_AWADDR,
   input  wire logic        I_AWVALID,
   output logic             O_AWREADY,
   input  wire logic [31:0] I_WDATA,
   input  wire logic [3:0]  I_WSTRB,
   input  wire logic        I_WVALID,
   output logic             O_WREADY,
   output logic [1:0]       O_BRESP,
   output logic             O_BVALID,
   input  wire logic        I_BREADY,
   input  wire logic [7:0]  I_ARADDR,
   input  wire logic        I_ARVALID,
   output logic             O_ARREADY,
   output logic [31:0]      O_RDATA,
   output logic [1:0]       O_RRESP,
   output logic             O_RVALID,
   input  wire logic        I_RREADY,
   input  wire logic [14:0] I_RX_LEVEL,
   input  wire logic        I_RX_PREAMBLE,
   input  wire da_info_t    I_RX_DA,
   input  wire logic        I_TX_BUSY,
   input  wire logic        I_TX_PAUSE_ACK,
   output logic             O_PAUSE_REQ,
   output logic             O_PAUSE_ZERO,
   output logic             O_JAM
);

   // ***************************************
   // Helpers
   // ***************************************
   function automatic logic addr_ok(input logic [7:0] a);
      addr_ok = (a == `ADDR_CTRL) || (a == `ADDR_STATUS) || (a == `ADDR_FLOW_CFG);
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] s);
      for (int i = 0; i < 4; i++) begin
         merge[i*8 +: 8] = s[i] ? d[i*8 +: 8] : old[i*8 +: 8];
      end
   endfunction

   function automatic logic [13:0] jam_cycles(input logic [3:0] code, input logic fast);
      int c;
      c = 0;
      case (code)
         4'h0: c = `JAM_T0_NS / `CLK_PERIOD_NS;
         4'h1: c = `JAM_T1_NS / `CLK_PERIOD_NS;
         4'h2: c = `JAM_T2_NS / `CLK_PERIOD_NS;
         4'h3: c = `JAM_T3_NS / `CLK_PERIOD_NS;
         default: c = (int'(code) - 3) * JAM_STEP_CYCLES;
      endcase
      if (!fast) begin
         c = c + `JAM_EXTRA_10M_NS / `CLK_PERIOD_NS;
      end
      jam_cycles = 14'(c);
   endfunction

   // ***************************************
   // Register bus
   // ***************************************
   flow_cfg_t   cfg_ff,   nxt_cfg;
   ctrl_t       ctrl_ff,  nxt_ctrl;
   logic        aw_got_ff, nxt_aw_got;
   logic        w_got_ff,  nxt_w_got;
   logic [7:0]  waddr_ff,  nxt_waddr;
   logic [31:0] wdata_ff,  nxt_wdata;
   logic [3:0]  wstrb_ff,  nxt_wstrb;
   logic        awready_ff, nxt_awready;
   logic        wready_ff,  nxt_wready;
   logic        bvalid_ff,  nxt_bvalid;
   logic [1:0]  bresp_ff,   nxt_bresp;
   logic        arready_ff, nxt_arready;
   logic        rvalid_ff,  nxt_rvalid;
   logic [1:0]  rresp_ff,   nxt_rresp;
   logic [31:0] rdata_ff,   nxt_rdata;
   logic [31:0] status;

   logic        above_ff, nxt_above;
   logic        paused_ff, nxt_paused;
   logic        pend_ff, nxt_pend;
   logic        req_ff, nxt_req;
   logic        zero_ff, nxt_zero;
   logic        jam_ff, nxt_jam;
   jam_state_t  jst_ff, nxt_jst;
   logic [13:0] cnt_ff, nxt_cnt;

   always_comb begin
      status      = {27'h000_0000, jam_ff, req_ff, pend_ff, paused_ff, above_ff};
      nxt_cfg     = cfg_ff;
      nxt_ctrl    = ctrl_ff;
      nxt_aw_got  = aw_got_ff;
      nxt_w_got   = w_got_ff;
      nxt_waddr   = waddr_ff;
      nxt_wdata   = wdata_ff;
      nxt_wstrb   = wstrb_ff;
      nxt_bvalid  = bvalid_ff;
      nxt_bresp   = bresp_ff;
      nxt_rvalid  = rvalid_ff;
      nxt_rresp   = rresp_ff;
      nxt_rdata   = rdata_ff;
      if (I_AWVALID && awready_ff) begin
         nxt_aw_got = 1'b1;
         nxt_waddr  = I_AWADDR;
      end
      if (I_WVALID && wready_ff) begin
         nxt_w_got = 1'b1;
         nxt_wdata = I_WDATA;
         nxt_wstrb = I_WSTRB;
      end
      if (bvalid_ff && I_BREADY) begin
         nxt_bvalid = 1'b0;
      end
      if (aw_got_ff && w_got_ff && !bvalid_ff) begin
         nxt_aw_got = 1'b0;
         nxt_w_got  = 1'b0;
         nxt_bvalid = 1'b1;
         nxt_bresp  = addr_ok(waddr_ff) ? `RESP_OKAY : `RESP_SLVERR;
         if (waddr_ff == `ADDR_CTRL) begin
            nxt_ctrl = ctrl_t'(3'(merge({29'h0000_0000, ctrl_ff}, wdata_ff, wstrb_ff)));
         end
         if (waddr_ff == `ADDR_FLOW_CFG) begin
            nxt_cfg = flow_cfg_t'(24'(merge({8'h00, cfg_ff}, wdata_ff, wstrb_ff)));
         end
      end
      if (rvalid_ff && I_RREADY) begin
         nxt_rvalid = 1'b0;
      end
      if (I_ARVALID && arready_ff) begin
         nxt_rvalid = 1'b1;
         nxt_rresp  = addr_ok(I_ARADDR) ? `RESP_OKAY : `RESP_SLVERR;
         case (I_ARADDR)
            `ADDR_CTRL:     nxt_rdata = {29'h0000_0000, ctrl_ff};
            `ADDR_STATUS:   nxt_rdata = status;
            `ADDR_FLOW_CFG: nxt_rdata = {8'h00, cfg_ff};
            default:        nxt_rdata = 32'h0000_0000;
         endcase
      end
      nxt_awready = !nxt_aw_got && !nxt_bvalid;
      nxt_wready  = !nxt_w_got && !nxt_bvalid;
      nxt_arready = !nxt_rvalid;
   end

   always_ff @(posedge I_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         cfg_ff     <= flow_cfg_t'(`CFG_RST);
         ctrl_ff    <= ctrl_t'(`CTRL_RST);
         aw_got_ff  <= 1'b0;
         w_got_ff   <= 1'b0;
         waddr_ff   <= 8'h00;
         wdata_ff   <= 32'h0000_0000;
         wstrb_ff   <= 4'h0;
         awready_ff <= 1'b0;
         wready_ff  <= 1'b0;
         bvalid_ff  <= 1'b0;
         bresp_ff   <= `RESP_OKAY;
         arready_ff <= 1'b0;
         rvalid_ff  <= 1'b0;
         rresp_ff   <= `RESP_OKAY;
         rdata_ff   <= 32'h0000_0000;
      end else begin
         cfg_ff     <= nxt_cfg;
         ctrl_ff    <= nxt_ctrl;
         aw_got_ff  <= nxt_aw_got;
         w_got_ff   <= nxt_w_got;
         waddr_ff   <= nxt_waddr;
         wdata_ff   <= nxt_wdata;
         wstrb_ff   <= nxt_wstrb;
         awready_ff <= nxt_awready;
         wready_ff  <= nxt_wready;
         bvalid_ff  <= nxt_bvalid;
         bresp_ff   <= nxt_bresp;
         arready_ff <= nxt_arready;
         rvalid_ff  <= nxt_rvalid;
         rresp_ff   <= nxt_rresp;
         rdata_ff   <= nxt_rdata;
      end
   end

   // ***************************************
   // Flow control trigger
   // ***************************************
   logic [14:0] hi_bytes;
   logic [14:0] lo_bytes;
   logic        above;
   logic        below;
   logic        hit;

   always_comb begin
      hi_bytes   = {1'b0, cfg_ff.flow_high_threshold, `THR_UNIT_BITS'(0)};
      lo_bytes   = {1'b0, cfg_ff.flow_low_threshold, `THR_UNIT_BITS'(0)};
      above      = I_RX_LEVEL >= hi_bytes;
      below      = I_RX_LEVEL < lo_bytes;
      hit        = cfg_ff.any_frame_flow_trigger ? I_RX_PREAMBLE :
                   I_RX_DA.valid && ((cfg_ff.multicast_flow_trigger && I_RX_DA.mcast) ||
                                     (cfg_ff.broadcast_flow_trigger && I_RX_DA.bcast) ||
                                     (cfg_ff.address_match_flow_trigger && I_RX_DA.match));
      nxt_above  = above;
      nxt_paused = paused_ff;
      nxt_pend   = pend_ff;
      nxt_zero   = zero_ff;
      nxt_jst    = jst_ff;
      nxt_cnt    = cnt_ff;
      if (req_ff && I_TX_PAUSE_ACK) begin
         nxt_pend = 1'b0;
      end
      if (!ctrl_ff.tx_enable) begin
         nxt_pend   = 1'b0;
         nxt_paused = 1'b0;
         nxt_jst    = J_IDLE;
         nxt_cnt    = 14'h0000;
      end else if (ctrl_ff.full_duplex) begin
         nxt_jst = J_IDLE;
         nxt_cnt = 14'h0000;
         if (cfg_ff.any_frame_flow_trigger && above && !above_ff) begin
            nxt_pend   = 1'b1;
            nxt_zero   = 1'b0;
            nxt_paused = 1'b1;
         end else if (paused_ff && below) begin
            nxt_pend   = 1'b1;
            nxt_zero   = 1'b1;
            nxt_paused = 1'b0;
         end
      end else begin
         nxt_pend   = 1'b0;
         nxt_paused = 1'b0;
         case (jst_ff)
            J_IDLE: begin
               if (above && hit) begin
                  nxt_jst = J_JAM;
                  nxt_cnt = jam_cycles(cfg_ff.jam_duration_select, ctrl_ff.speed_100);
               end
            end
            J_JAM: begin
               nxt_cnt = cnt_ff - 14'h0001;
               if (cnt_ff <= 14'h0001) begin
                  nxt_jst = J_IDLE;
               end
            end
            default: begin
               nxt_jst = J_IDLE;
            end
         endcase
      end
      nxt_req = nxt_pend && (req_ff || !I_TX_BUSY);
      nxt_jam = nxt_jst == J_JAM;
   end

   always_ff @(posedge I_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         above_ff  <= 1'b0;
         paused_ff <= 1'b0;
         pend_ff   <= 1'b0;
         req_ff    <= 1'b0;
         zero_ff   <= 1'b0;
         jam_ff    <= 1'b0;
         jst_ff    <= J_IDLE;
         cnt_ff    <= 14'h0000;
      end else begin
         above_ff  <= nxt_above;
         paused_ff <= nxt_paused;
         pend_ff   <= nxt_pend;
         req_ff    <= nxt_req;
         zero_ff   <= nxt_zero;
         jam_ff    <= nxt_jam;
         jst_ff    <= nxt_jst;
         cnt_ff    <= nxt_cnt;
      end
   end

   // ***************************************
   // Outputs
   // ***************************************
   assign O_AWREADY    = awready_ff;
   assign O_WREADY     = wready_ff;
   assign O_BVALID     = bvalid_ff;
   assign O_BRESP      = bresp_ff;
   assign O_ARREADY    = arready_ff;
   assign O_RVALID     = rvalid_ff;
   assign O_RRESP      = rresp_ff;
   assign O_RDATA      = rdata_ff;
   assign O_PAUSE_REQ  = req_ff;
   assign O_PAUSE_ZERO = zero_ff;
   assign O_JAM        = jam_ff;

endmodule

// ===== flow_trigger_sva.sv
// Port checker of the flow trigger
// Assumes it is bound into flow_trigger, one clock
`timescale 1ns/100ps
module flow_trigger_sva
   import flow_trig_pkg::*;
#(
   parameter int JAM_STEP_CYCLES = 1000
) (
   input wire logic        I_CLK,
   input wire logic        I_RST_B,
   input wire logic        I_BREADY,
   input wire logic        I_RREADY,
   input wire logic        I_RX_PREAMBLE,
   input wire da_info_t    I_RX_DA,
   input wire logic        I_TX_BUSY,
   input wire logic        I_TX_PAUSE_ACK,
   input wire logic        O_AWREADY,
   input wire logic        O_WREADY,
   input wire logic [1:0]  O_BRESP,
   input wire logic        O_BVALID,
   input wire logic        O_ARREADY,
   input wire logic [31:0] O_RDATA,
   input wire logic        O_RVALID,
   input wire logic        O_PAUSE_REQ,
   input wire logic        O_PAUSE_ZERO,
   input wire logic        O_JAM
);
   localparam int JAM_MAX = (12 * JAM_STEP_CYCLES > 500 ? 12 * JAM_STEP_CYCLES : 500) + 44;
   int unsigned jam_cnt_ff;
   int unsigned nxt_jam_cnt;
   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (!I_RST_B);
   always_comb nxt_jam_cnt = O_JAM ? jam_cnt_ff + 1 : 0;
   always_ff @(posedge I_CLK or negedge I_RST_B) begin
      if (!I_RST_B) jam_cnt_ff <= 0;
      else jam_cnt_ff <= nxt_jam_cnt;
   end
   sequence s_b_wait; O_BVALID && !I_BREADY; endsequence
   sequence s_r_wait; O_RVALID && !I_RREADY; endsequence
   sequence s_req_wait; O_PAUSE_REQ && !I_TX_PAUSE_ACK; endsequence
   a_bresp_stands: assert property (s_b_wait |=> O_BVALID && $stable(O_BRESP))
      else $error("write response dropped");
   a_rdata_stands: assert property (s_r_wait |=> O_RVALID && $stable(O_RDATA))
      else $error("read data dropped");
   a_ar_blocked: assert property (O_RVALID |-> !O_ARREADY) else $error("read overlap");
   a_w_blocked: assert property (O_BVALID |-> !O_AWREADY && !O_WREADY)
      else $error("write overlap");
   a_pause_held: assert property (s_req_wait |=> O_PAUSE_REQ && $stable(O_PAUSE_ZERO))
      else $error("pause request dropped");
   a_pause_idle: assert property ($rose(O_PAUSE_REQ) |-> !$past(I_TX_BUSY))
      else $error("pause cut into a frame");
   a_jam_cause: assert property ($rose(O_JAM) |-> $past(I_RX_PREAMBLE) || $past(I_RX_DA.valid))
      else $error("jam without frame");
   a_jam_bound: assert property (O_JAM |-> jam_cnt_ff <= JAM_MAX)
      else $error("jam too long");
endmodule
bind flow_trigger flow_trigger_sva #(.JAM_STEP_CYCLES(JAM_STEP_CYCLES)) i_sva (
   .I_CLK, .I_RST_B, .I_BREADY, .I_RREADY, .I_RX_PREAMBLE, .I_RX_DA, .I_TX_BUSY,
   .I_TX_PAUSE_ACK, .O_AWREADY, .O_WREADY, .O_BRESP, .O_BVALID, .O_ARREADY, .O_RDATA,
   .O_RVALID, .O_PAUSE_REQ, .O_PAUSE_ZERO, .O_JAM);

// ===== mac_tx_model.sv
// MAC transmitter model: frames in flight and the pause handshake
// Assumes the flow trigger clock and reset
`timescale 1ns/100ps
module mac_tx_model (
   input  wire logic i_clk,
   input  wire logic i_rst_b,
   input  wire logic i_pause_req,
   input  wire logic i_slow,
   output logic      o_tx_busy,
   output logic      o_pause_ack
);
   logic [4:0] cnt_ff;
   assign o_tx_busy = i_slow && cnt_ff[4];
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         cnt_ff      <= 5'h00;
         o_pause_ack <= 1'b0;
      end else begin
         cnt_ff      <= cnt_ff + 5'h01;
         o_pause_ack <= i_pause_req && !o_pause_ack && !o_tx_busy
                        && (!i_slow || cnt_ff[3:0] == 4'h4);
      end
   end
endmodule

// ===== flow_trigger_tb.sv
// Self-checking bench of the flow trigger
// Assumes the package, header, checker and MAC model are compiled first
`timescale 1ns/100ps
`include "flow_trig_consts.svh"
module flow_trigger_tb;
   import flow_trig_pkg::*;
   localparam int STEP = 10;
   logic        I_CLK = 0, I_RST_B = 0, I_AWVALID = 0, I_WVALID = 0, I_BREADY = 0;
   logic        I_ARVALID = 0, I_RREADY = 0, I_RX_PREAMBLE = 0, slow = 0;
   logic [7:0]  I_AWADDR = 0, I_ARADDR = 0;
   logic [31:0] I_WDATA = 0, O_RDATA, r;
   logic [3:0]  I_WSTRB = 4'hF;
   logic [14:0] I_RX_LEVEL = 0;
   da_info_t    I_RX_DA = '0;
   logic        I_TX_BUSY, I_TX_PAUSE_ACK, O_AWREADY, O_WREADY, O_BVALID, O_ARREADY;
   logic        O_RVALID, O_PAUSE_REQ, O_PAUSE_ZERO, O_JAM;
   logic [1:0]  O_BRESP, O_RRESP;
   logic [33:0] exp_rd[$];
   logic [1:0]  exp_b[$];
   logic        exp_p[$];
   int          exp_j[$];
   int          mismatches = 0, n_checks = 0, seed = 87, jam_n = 0;
   always #25 I_CLK = ~I_CLK;
   flow_trigger #(.JAM_STEP_CYCLES(STEP)) i_dut (.*);
   mac_tx_model i_mac (.i_clk(I_CLK), .i_rst_b(I_RST_B), .i_pause_req(O_PAUSE_REQ),
      .i_slow(slow), .o_tx_busy(I_TX_BUSY), .o_pause_ack(I_TX_PAUSE_ACK));
   // ****************************************
   // Checking and closing
   // ****************************************
   task automatic check(input string nm, input logic [33:0] seen, input logic [33:0] e);
      n_checks++;
      if (seen !== e) begin
         mismatches++;
         $display("CHECK FAILED %s exp %h seen %h", nm, e, seen);
      end
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   always @(posedge I_CLK) begin
      if (O_BVALID && I_BREADY) check("bresp", O_BRESP, exp_b.pop_front());
      if (O_RVALID && I_RREADY) check("rdata", {O_RRESP, O_RDATA}, exp_rd.pop_front());
      if (O_PAUSE_REQ && I_TX_PAUSE_ACK) check("zero", O_PAUSE_ZERO, exp_p.pop_front());
      if (O_JAM) jam_n++;
      else if (jam_n > 0) begin
         check("jam_len", jam_n, exp_j.pop_front());
         jam_n = 0;
      end
   end
   // ****************************************
   // Drivers
   // ****************************************
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [33:0] e);
      int n;
      @(posedge I_CLK);
      if (w) exp_b.push_back(e[33:32]);
      else exp_rd.push_back(e);
      I_AWADDR  <= a;
      I_ARADDR  <= a;
      I_WDATA   <= d;
      I_AWVALID <= w;
      I_WVALID  <= w;
      I_ARVALID <= !w;
      for (n = 0; n < 40; n++) begin
         @(posedge I_CLK);
         if (O_AWREADY) I_AWVALID <= 0;
         if (O_WREADY) I_WVALID <= 0;
         if (O_ARREADY) I_ARVALID <= 0;
         if (w ? O_BVALID && I_BREADY : O_RVALID && I_RREADY) break;
         if (n == 2) begin
            I_BREADY <= w;
            I_RREADY <= !w;
         end
      end
      I_BREADY <= 0;
      I_RREADY <= 0;
      if (n == 40) begin
         mismatches++;
         close_out();
      end
   endtask
   task automatic lvl(input logic [14:0] v, input int p);
      @(posedge I_CLK);
      I_RX_LEVEL <= v;
      if (p >= 0) exp_p.push_back(p[0]);
      repeat (40) @(posedge I_CLK);
   endtask
   task automatic hit(input logic pre, input da_info_t da, input int len);
      @(posedge I_CLK);
      I_RX_PREAMBLE <= pre;
      I_RX_DA       <= da;
      if (len > 0) exp_j.push_back(len);
      @(posedge I_CLK);
      I_RX_PREAMBLE <= 0;
      I_RX_DA       <= '0;
      repeat (len + 8) @(posedge I_CLK);
   endtask
   function automatic int jam_len(input int c, input logic s100);
      int t[4] = '{`JAM_T0_NS, `JAM_T1_NS, `JAM_T2_NS, `JAM_T3_NS};
      return (c < 4 ? t[c] / `CLK_PERIOD_NS : (c - 3) * STEP)
             + (s100 ? 0 : `JAM_EXTRA_10M_NS / `CLK_PERIOD_NS);
   endfunction
   initial begin
      repeat (2) @(posedge I_CLK);
      I_RST_B <= 1;
      bus(0, `ADDR_CTRL, 0, 34'h0);
      bus(0, `ADDR_FLOW_CFG, 0, 34'h0);
      bus(0, 8'h10, 0, {`RESP_SLVERR, 32'h0000_0000});
      bus(1, 8'h10, 32'hFFFF_FFFF, {`RESP_SLVERR, 32'h0000_0000});
      r = $random(seed);
      bus(1, `ADDR_FLOW_CFG, r, 34'h0);
      bus(0, `ADDR_FLOW_CFG, 0, {2'h0, 8'h00, r[23:0]});
      bus(1, `ADDR_CTRL, 32'h0000_0007, 34'h0);
      bus(0, `ADDR_CTRL, 0, 34'h0_0000_0007);
      bus(1, `ADDR_FLOW_CFG, 32'h0004_020E, 34'h0);
      lvl(15'd256, -1);
      r = $random(seed);
      lvl(r[14:0] & 15'h00FF, -1);
      bus(1, `ADDR_FLOW_CFG, 32'h0004_02F1, 34'h0);
      slow <= 1;
      lvl(15'd256, 0);
      hit(1, '0, 0);
      lvl(15'd300, -1);
      bus(0, `ADDR_STATUS, 0, 34'h0_0000_0003);
      lvl(15'd128, -1);
      lvl(15'd127, 1);
      slow <= 0;
      lvl(15'd256, 0);
      lvl(15'd100, 1);
      bus(1, `ADDR_CTRL, 32'h0000_0006, 34'h0);
      lvl(15'd300, -1);
      lvl(15'd100, -1);
      bus(1, `ADDR_CTRL, 32'h0000_0007, 34'h0);
      lvl(15'd200, -1);
      lvl(15'd100, -1);
      bus(1, `ADDR_CTRL, 32'h0000_0005, 34'h0);
      bus(1, `ADDR_FLOW_CFG, 32'h0004_0041, 34'h0);
      hit(1, '0, 0);
      lvl(15'd300, -1);
      bus(0, `ADDR_STATUS, 0, 34'h0_0000_0001);
      hit(0, 4'b1100, 0);
      hit(1, '0, jam_len(4, 1));
      bus(1, `ADDR_FLOW_CFG, 32'h0004_0048, 34'h0);
      hit(1, '0, 0);
      hit(0, 4'b1010, 0);
      hit(0, 4'b1100, jam_len(4, 1));
      for (int s = 0; s < 2; s++) begin
         for (int c = 0; c < 16; c++) begin
            bus(1, `ADDR_CTRL, {29'h0, s[0], 2'h1}, 34'h0);
            bus(1, `ADDR_FLOW_CFG, {16'h0004, 8'h00, c[3:0], 4'h1}, 34'h0);
            hit(1, '0, jam_len(c, s[0]));
         end
      end
      check("left", exp_p.size() + exp_j.size() + exp_b.size() + exp_rd.size(), 0);
      close_out();
   end
endmodule
